// ==== logic/spims_pkg.sv ====
// Package of the serial peripheral port: register map, field positions,
// reset values and clock divider figures.
// Assumes a 32-bit Avalon-MM slave with byte addresses, data in bits 7..0.
package spims_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [4:0] SPIMS_OFS_MODE = 5'h00;
  localparam logic [4:0] SPIMS_OFS_CTL2 = 5'h04;
  localparam logic [4:0] SPIMS_OFS_DATA = 5'h08;
  localparam logic [4:0] SPIMS_OFS_ISTAT = 5'h0c;
  localparam logic [4:0] SPIMS_OFS_IMASK = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // mode_control_reg fields
  localparam int SPIMS_MODE_HI = 7;
  localparam int SPIMS_MODE_LO = 5;
  localparam int SPIMS_UMD_BIT = 4;
  localparam int SPIMS_EN_BIT = 1;
  localparam logic [2:0] SPIMS_MODE_RST = 3'h7;

  // operating_mode_field codes
  localparam logic [2:0] SPIMS_M_DIV4 = 3'h0;
  localparam logic [2:0] SPIMS_M_DIV16 = 3'h1;
  localparam logic [2:0] SPIMS_M_DIV64 = 3'h2;
  localparam logic [2:0] SPIMS_M_SUB = 3'h3;
  localparam logic [2:0] SPIMS_M_TMR = 3'h4;
  localparam logic [2:0] SPIMS_M_SLAVE = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // spi_control_two fields
  localparam int SPIMS_POL_BIT = 5;
  localparam int SPIMS_EDGE_BIT = 4;
  localparam int SPIMS_MSB_BIT = 3;
  localparam int SPIMS_SELECT_PIN_ENABLE_BIT = 2;
  localparam int SPIMS_WRITE_COLLISION_FLAG_BIT = 1;
  localparam int SPIMS_TRF_BIT = 0;

  // Interrupt status and mask fields
  localparam int SPIMS_IRQ_DONE = 0;
  localparam int SPIMS_IRQ_COL = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Half SCK period in system clocks for the divided master rates
  localparam logic [4:0] SPIMS_HALF_DIV4 = 5'h02;
  localparam logic [4:0] SPIMS_HALF_DIV16 = 5'h08;
  localparam logic [5:0] SPIMS_HALF_DIV64 = 6'h20;

  // Bits per word and index of the last of the 16 SCK edges per word
  localparam int SPIMS_WORD_BITS = 8;
  localparam logic [4:0] SPIMS_LAST_EDGE = 5'h0f;

  typedef enum logic {SPIMS_IDLE, SPIMS_RUN} spims_state_e;

endpackage

// ==== logic/spims_sync.sv ====
// Two-flop synchroniser with edge detection for a group of pins.
// Assumes inputs come from outside the i_clk domain.
module spims_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pins
  input wire logic [W-1:0] i_d,
  // Synchronised level and edges
  output logic [W-1:0] o_q,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
    logic [W-1:0] prev;
    logic [2:0] live;
  } spims_sync_s;

  spims_sync_s s_r;
  spims_sync_s s_nxt;

  always_comb begin
    s_nxt.meta = i_d;
    s_nxt.q = s_r.meta;
    s_nxt.prev = s_r.q;
    s_nxt.live = {s_r.live[1:0], 1'b1};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // No edges until prev holds a real pin sample, so reset makes none
  assign o_q = s_r.q;
  assign o_rise = s_r.q & ~s_r.prev & {W{s_r.live[2]}};
  assign o_fall = ~s_r.q & s_r.prev & {W{s_r.live[2]}};

endmodule // spims_sync

// ==== logic/spims_top.sv ====
// Serial peripheral port, master or slave, with Avalon-MM registers.
// Assumes pins are resolved outside from the value and output-enable pairs.
//
// Overview of operation
// RULE_01 - Select pin floats and is ignored unless enabled
// RULE_02 - Write during transfer dropped, sets collision flag
// RULE_03 - Completed transfer sets done flag, software clears
// RULE_04 - Master: data write starts full-duplex transfer
// RULE_05 - Slave: external clock shifts data out/in
// RULE_06 - Master selects slave before clocking
// RULE_07 - Slave output timing follows polarity and edge
// RULE_08 - Keeps running while its clock source runs
// RULE_09 - Disabled interface releases all four pins
// RULE_10 - Idle: SDI floats, SDO high, SCK per mode (a slave with edge select one holds SDO at its first data bit)
// RULE_11 - Master makes SCK; slave takes external SCK
// RULE_12 - Received bits reach data register only whole
// RULE_13 - Bit order must match on both ends
// RULE_14 - Bus active with select enabled and low
// RULE_15 - Software sequence: configure, write, wait, read, clear
// RULE_16 - Mode field picks master rate or slave
// RULE_17 - Polarity one idles SCK low, zero high
// RULE_18 - Each transfer moves exactly eight bits
//
// Added by the designer: the Avalon-MM slave port and the address map.
module spims_top
  import spims_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Avalon-MM slave
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Interrupt
  output logic o_irq,
  // Master clock sources
  input wire logic i_subclk,
  input wire logic i_timer_match,
  // SPI pins
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  input wire logic i_select_pin_n,
  output logic o_select_pin_n,
  output logic o_select_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [2:0] mode;
    logic uart_mode_select;
    logic en;
    logic polb;
    logic clock_edge_select;
    logic msbf;
    logic select_pin_enable;
    logic write_collision_flag;
    logic transfer_done_flag;
    logic [7:0] data;
    logic [7:0] shbuf;
    logic [4:0] cnt;
    logic [5:0] div;
    spims_state_e st;
    logic sck;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic sel_n;
    logic sel_oe_n;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
    logic wait_r;
    logic [31:0] rdata;
    logic smp;
    logic fin;
  } spims_s;

  localparam spims_s SPIMS_RST_S = '{
    mode: SPIMS_MODE_RST, st: SPIMS_IDLE, sck_oe_n: 1'b1, sdo: 1'b1,
    sdo_oe_n: 1'b1, sel_n: 1'b1, sel_oe_n: 1'b1, wait_r: 1'b1,
    default: '0};

  function automatic logic out_bit(input logic [7:0] b, input logic msb);
    out_bit = msb ? b[SPIMS_WORD_BITS-1] : b[0];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] b,
                                          input logic msb, input logic d);
    shift_in = msb ? {b[6:0], d} : {d, b[7:1]};
  endfunction

  spims_s s_r;
  spims_s s_nxt;
  logic rst_m_r;
  logic rst_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  logic [3:0] pin_q;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;

  spims_sync #(.W(4)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n_r),
    .i_d({i_subclk, i_select_pin_n, i_sdi, i_sck}),
    .o_q(pin_q),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic spi_on;
  logic master;
  logic idle_lvl;
  logic tick;
  logic [5:0] half;
  logic selected;
  logic ev_lead;
  logic ev_trail;
  logic ev_drive;
  logic ev_sample;
  logic run;
  logic busy;
  logic req;
  logic wr_go;
  logic [7:0] wb;
  logic [7:0] nb;
  logic hit_col;
  logic hit_done;

  always_comb begin
    s_nxt = s_r;
    spi_on = s_r.en && !s_r.uart_mode_select && (s_r.mode <= SPIMS_M_SLAVE);
    master = s_r.mode < SPIMS_M_SLAVE;
    idle_lvl = !s_r.polb; // RULE_17
    hit_col = 1'b0;
    hit_done = 1'b0;
    wb = i_writedata[7:0];
    nb = s_r.shbuf;
    // Master bit rate source
    case (s_r.mode) // RULE_16
      SPIMS_M_DIV4: half = {1'b0, SPIMS_HALF_DIV4};
      SPIMS_M_DIV16: half = {1'b0, SPIMS_HALF_DIV16};
      SPIMS_M_DIV64: half = SPIMS_HALF_DIV64;
      default: half = 6'h01;
    endcase
    case (s_r.mode) // RULE_08
      SPIMS_M_DIV4, SPIMS_M_DIV16, SPIMS_M_DIV64:
        tick = (s_r.div == half - 6'h01);
      SPIMS_M_SUB: tick = pin_rise[3] | pin_fall[3];
      SPIMS_M_TMR: tick = i_timer_match;
      default: tick = 1'b0;
    endcase
    selected = !s_r.select_pin_enable || !pin_q[2]; // RULE_01 RULE_14
    run = (s_r.st == SPIMS_RUN) && !s_r.fin;
    busy = s_r.fin || (master ? (s_r.st == SPIMS_RUN) : (s_r.cnt != 5'h00));
    // Clock edges: internal toggles as master, pin edges as slave
    if (master) begin // RULE_11
      ev_lead = spi_on && run && tick && (s_r.sck == idle_lvl);
      ev_trail = spi_on && run && tick && (s_r.sck != idle_lvl);
    end else begin
      ev_lead = spi_on && selected &&
                (s_r.polb ? pin_rise[0] : pin_fall[0]);
      ev_trail = spi_on && selected &&
                 (s_r.polb ? pin_fall[0] : pin_rise[0]);
    end
    ev_drive = s_r.clock_edge_select ? ev_trail : ev_lead; // RULE_07
    ev_sample = s_r.clock_edge_select ? ev_lead : ev_trail;

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM: answer one cycle after the request appears
    req = i_read || i_write;
    s_nxt.wait_r = !(req && s_r.wait_r);
    wr_go = i_write && !s_r.wait_r && i_byteenable[0];
    if (i_read && s_r.wait_r) begin
      case (i_address)
        SPIMS_OFS_MODE: s_nxt.rdata = {24'h0, s_r.mode, s_r.uart_mode_select, 2'h0,
                                       s_r.en, 1'h0};
        SPIMS_OFS_CTL2: s_nxt.rdata = {26'h0, s_r.polb, s_r.clock_edge_select,
                                       s_r.msbf, s_r.select_pin_enable, s_r.write_collision_flag,
                                       s_r.transfer_done_flag};
        SPIMS_OFS_DATA: s_nxt.rdata = {24'h0, s_r.data};
        SPIMS_OFS_ISTAT: s_nxt.rdata = {30'h0, s_r.istat};
        SPIMS_OFS_IMASK: s_nxt.rdata = {30'h0, s_r.imask};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    if (wr_go) begin
      case (i_address)
        SPIMS_OFS_MODE: begin
          s_nxt.mode = wb[SPIMS_MODE_HI:SPIMS_MODE_LO];
          s_nxt.uart_mode_select = wb[SPIMS_UMD_BIT];
          s_nxt.en = wb[SPIMS_EN_BIT];
        end
        SPIMS_OFS_CTL2: begin
          s_nxt.polb = wb[SPIMS_POL_BIT];
          s_nxt.clock_edge_select = wb[SPIMS_EDGE_BIT];
          s_nxt.msbf = wb[SPIMS_MSB_BIT]; // RULE_13
          s_nxt.select_pin_enable = wb[SPIMS_SELECT_PIN_ENABLE_BIT];
          s_nxt.write_collision_flag = s_r.write_collision_flag & wb[SPIMS_WRITE_COLLISION_FLAG_BIT];
          s_nxt.transfer_done_flag = s_r.transfer_done_flag & wb[SPIMS_TRF_BIT];
        end
        SPIMS_OFS_DATA: begin
          if (busy) begin
            hit_col = 1'b1; // RULE_02
          end else begin
            s_nxt.data = wb;
            s_nxt.shbuf = wb;
            if (spi_on && master) begin
              s_nxt.st = SPIMS_RUN; // RULE_04
              s_nxt.cnt = 5'h00;
              s_nxt.div = 6'h00;
            end
          end
        end
        SPIMS_OFS_ISTAT: s_nxt.istat = s_r.istat & ~wb[1:0];
        SPIMS_OFS_IMASK: s_nxt.imask = wb[1:0];
        default: ;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift engine
    if (master && run) begin
      s_nxt.div = tick ? 6'h00 : s_r.div + 6'h01;
      if (tick) begin
        s_nxt.sck = !s_r.sck;
      end
    end
    // SDI lags the pin by two flops, so take it one clock after the edge
    s_nxt.smp = ev_sample;
    if (s_r.smp) begin
      nb = shift_in(s_r.shbuf, s_r.msbf, pin_q[1]); // RULE_05
      s_nxt.shbuf = nb;
    end
    if (ev_drive) begin
      s_nxt.sdo = out_bit(s_r.shbuf, s_r.msbf);
    end
    if (ev_lead || ev_trail) begin
      s_nxt.cnt = s_r.cnt + 5'h01;
      if (s_r.cnt == SPIMS_LAST_EDGE) begin // RULE_18
        s_nxt.cnt = 5'h00;
        s_nxt.fin = 1'b1;
      end
    end
    // Finish once the last sample is in
    if (s_r.fin) begin
      s_nxt.fin = 1'b0;
      s_nxt.st = SPIMS_IDLE;
      s_nxt.data = nb; // RULE_12
      hit_done = 1'b1;
    end
    if (!master && !selected) begin
      s_nxt.cnt = 5'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pins
    if (!spi_on) begin // RULE_09
      s_nxt.smp = 1'b0;
      s_nxt.fin = 1'b0;
      s_nxt.st = SPIMS_IDLE;
      s_nxt.cnt = 5'h00;
      s_nxt.sck = idle_lvl;
      s_nxt.sck_oe_n = 1'b1;
      s_nxt.sdo = 1'b1;
      s_nxt.sdo_oe_n = 1'b1;
      s_nxt.sel_n = 1'b1;
      s_nxt.sel_oe_n = 1'b1;
    end else begin
      s_nxt.sdo_oe_n = 1'b0;
      s_nxt.sck_oe_n = !master; // RULE_10 RULE_11
      s_nxt.sel_oe_n = !(master && s_r.select_pin_enable); // RULE_01
      s_nxt.sel_n = !(s_nxt.st == SPIMS_RUN); // RULE_06 RULE_14
      if (s_nxt.st == SPIMS_IDLE && master) begin
        s_nxt.sck = idle_lvl; // RULE_10 RULE_17
      end
      if (s_nxt.cnt == 5'h00 && !(ev_lead || ev_trail)) begin
        // Edge mode one needs the first bit out before the first edge
        s_nxt.sdo = (s_r.clock_edge_select && (master ? s_nxt.st == SPIMS_RUN : 1'b1))
                    ? out_bit(s_nxt.shbuf, s_r.msbf) : 1'b1; // RULE_07
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flags and interrupt; a set wins over a clear in the same cycle
    if (hit_col) begin
      s_nxt.write_collision_flag = 1'b1; // RULE_02
      s_nxt.istat[SPIMS_IRQ_COL] = 1'b1;
    end
    if (hit_done) begin
      s_nxt.transfer_done_flag = 1'b1; // RULE_03
      s_nxt.istat[SPIMS_IRQ_DONE] = 1'b1;
    end
    s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
  end

  always_ff @(posedge i_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= SPIMS_RST_S;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_readdata = s_r.rdata;
  assign o_waitrequest = s_r.wait_r;
  assign o_irq = s_r.irq;
  assign o_sck = s_r.sck;
  assign o_sck_oe_n = s_r.sck_oe_n;
  assign o_sdo = s_r.sdo;
  assign o_sdo_oe_n = s_r.sdo_oe_n;
  assign o_select_pin_n = s_r.sel_n;
  assign o_select_pin_oe_n = s_r.sel_oe_n;

endmodule // spims_top

// ==== test/spims_properties.sv ====
// Checker of the serial port pins and the register bus handshake.
// Assumes it is bound to spims_top and sees only its ports.
module spims_properties
  import spims_pkg::*;
(
  // Watched ports
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [4:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [3:0] i_byteenable,
  input wire logic o_waitrequest,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_sdo,
  input wire logic o_sdo_oe_n,
  input wire logic o_select_pin_n,
  input wire logic o_select_pin_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic sck_q;
  logic [4:0] tog_r;
  // Counts SCK toggles while select is low
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_q <= 1'b0;
      tog_r <= 5'h0;
    end else begin
      sck_q <= o_sck;
      tog_r <= o_select_pin_n ? 5'h0 : tog_r + 5'(o_sck != sck_q);
    end
  end
  a_bus_answer: assert property (
    (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("bus request not answered");
  a_wait_pulse: assert property (
    $fell(o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest low too long");
  a_pins_release: assert property (
    o_sdo_oe_n |-> o_sck_oe_n && o_select_pin_oe_n)
    else $error("pin driven while disabled");
  a_sck_master: assert property (
    !o_select_pin_oe_n && !o_select_pin_n |-> !o_sck_oe_n)
    else $error("master transfer without SCK drive");
  a_write_start: assert property (
    i_write && !o_waitrequest && i_address == SPIMS_OFS_DATA &&
    i_byteenable[0] && o_select_pin_n && !o_select_pin_oe_n
    |-> ##[1:2] !o_select_pin_n)
    else $error("data write did not start transfer");
  a_edge_count: assert property (
    $rose(o_select_pin_n) && !o_select_pin_oe_n
    |-> tog_r + 5'(o_sck != sck_q) == 5'h10)
    else $error("transfer edge count wrong");
  a_sel_hold: assert property (
    $fell(o_select_pin_n) |-> !o_select_pin_n [*8])
    else $error("select released early");
  a_idle_sdo: assert property (
    !o_sdo_oe_n && !o_select_pin_oe_n && o_select_pin_n &&
    $past(o_select_pin_n) |-> o_sdo)
    else $error("idle data out not high");
endmodule // spims_properties
bind spims_top spims_properties spims_properties_inst (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_address(i_address),
  .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable),
  .o_waitrequest(o_waitrequest), .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n),
  .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_select_pin_n(o_select_pin_n),
  .o_select_pin_oe_n(o_select_pin_oe_n));

// ==== test/spims_partner.sv ====
// Model of the far-side SPI device, in slave or master role.
// Assumes idle-low SCK, data changed on leading edge, MSB first.
module spims_partner (
  // Resolved pins
  input wire logic i_sck,
  input wire logic i_sel_n,
  input wire logic i_sdo,
  // Driven pins
  output logic o_sdi,
  output logic o_sck,
  output logic o_sel_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_r = 8'h0;
  logic [7:0] rx_r = 8'h0;
  logic master_r = 1'b0;
  initial begin
    o_sdi = 1'b0;
    o_sck = 1'b0;
    o_sel_n = 1'b1;
  end
  // Slave role: next bit on leading edge, MSB first
  always @(posedge i_sck) if (!master_r && !i_sel_n) begin
    o_sdi <= tx_r[7];
    tx_r <= {tx_r[6:0], 1'b0};
  end
  always @(negedge i_sck) if (!i_sel_n) rx_r <= {rx_r[6:0], i_sdo};
  // Released data line shows no stale value
  always @(posedge i_sel_n) o_sdi <= ~o_sdi;
  // Master role: select first, then eight SCK pulses, 400 ns high and 400 ns low
  task automatic run_master();
    master_r = 1'b1;
    o_sel_n = 1'b0;
    #437;
    repeat (8) begin
      o_sck = 1'b1;
      o_sdi = tx_r[7];
      tx_r = {tx_r[6:0], 1'b0};
      #400;
      o_sck = 1'b0;
      #400;
    end
    o_sel_n = 1'b1;
    master_r = 1'b0;
  endtask
endmodule // spims_partner

// ==== test/test_spi_master_slave_port.sv ====
// Self-checking bench of the serial port: registers, master, slave.
// Assumes spims_top, its checker and the partner model.
module test_spi_master_slave_port;
  import spims_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] addr = 5'h0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] div = 4'h0;
  logic tm = 1'b0;
  logic sub = 1'b0;
  logic [31:0] rdata;
  logic wreq, irq, sck_o, sck_oe, sdo_o, sdo_oe, sel_o, sel_oe;
  logic p_sdi, p_sck, p_sel;
  wire logic sck, sdo, sel;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int checks_done = 0;
  logic [7:0] d, p;
  always #50 clk = ~clk;
  // Subclock and timer match sources
  always @(posedge clk) begin
    div <= div + 4'h1;
    tm <= div == 4'h0;
    sub <= div[3];
  end
  assign sck = sck_oe ? p_sck : sck_o;
  assign sel = sel_oe ? p_sel : sel_o;
  assign sdo = sdo_oe ? 1'b1 : sdo_o;
  spims_top spims_top_inst (
    .i_clk(clk), .i_rstn(rstn), .i_address(addr), .i_read(rd_s),
    .i_write(wr_s), .i_byteenable(4'hf), .i_writedata(wd),
    .o_readdata(rdata), .o_waitrequest(wreq), .o_irq(irq),
    .i_subclk(sub), .i_timer_match(tm), .i_sck(sck), .o_sck(sck_o),
    .o_sck_oe_n(sck_oe), .i_sdi(p_sdi), .o_sdo(sdo_o), .o_sdo_oe_n(sdo_oe),
    .i_select_pin_n(sel), .o_select_pin_n(sel_o),
    .o_select_pin_oe_n(sel_oe));
  spims_partner spims_partner_inst (
    .i_sck(sck), .i_sel_n(sel), .i_sdo(sdo), .o_sdi(p_sdi),
    .o_sck(p_sck), .o_sel_n(p_sel));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  always @(posedge clk) if (rd_s && !wreq)
    chk(rdata, exp_q.pop_front());
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= {24'h0, v};
    wr_s <= w;
    rd_s <= !w;
    do @(posedge clk); while (wreq);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(a, 1'b0, 8'h0);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    err_total++;
    end_of_test();
  end
  initial begin
    d = 8'($urandom(32'hbd72));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(SPIMS_OFS_MODE, 8'he0);
    rd(SPIMS_OFS_CTL2, 8'h00);
    rd(5'h14, 8'h00);
    bus(SPIMS_OFS_IMASK, 1'b1, 8'h01);
    bus(SPIMS_OFS_MODE, 1'b1, 8'h02);
    bus(SPIMS_OFS_CTL2, 1'b1, 8'h0c);
    repeat (2) @(posedge clk);
    chk(sck, 1);
    $display("test reset values done");
    for (int m = 0; m < 6; m++) begin
      d = 8'($urandom);
      p = 8'($urandom);
      spims_partner_inst.tx_r = p;
      bus(SPIMS_OFS_MODE, 1'b1, {m[2:0], 5'h02});
      bus(SPIMS_OFS_CTL2, 1'b1, 8'h2c);
      repeat (2) @(posedge clk);
      chk(sck, 0);
      bus(SPIMS_OFS_DATA, 1'b1, d);
      if (m == 0) bus(SPIMS_OFS_DATA, 1'b1, ~d);
      if (m == 5) spims_partner_inst.run_master();
      for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
      chk(irq, 1);
      chk(spims_partner_inst.rx_r, d);
      rd(SPIMS_OFS_DATA, p);
      rd(SPIMS_OFS_CTL2, m == 0 ? 8'h2f : 8'h2d);
      if (m == 1) begin
        bus(SPIMS_OFS_IMASK, 1'b1, 8'h00);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        bus(SPIMS_OFS_IMASK, 1'b1, 8'h01);
      end
      bus(SPIMS_OFS_CTL2, 1'b1, 8'h2c);
      rd(SPIMS_OFS_CTL2, 8'h2c);
      bus(SPIMS_OFS_ISTAT, 1'b1, 8'h03);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      $display("test %0d done", m);
    end
    bus(SPIMS_OFS_MODE, 1'b1, 8'h00);
    repeat (2) @(posedge clk);
    chk({sck_oe, sdo_oe, sel_oe}, 3'h7);
    $display("test disable done");
    end_of_test();
  end
endmodule // test_spi_master_slave_port
